// *** pkg/phy_mgmt_pkg.sv ***
package phy_mgmt_pkg;
  localparam logic [5:0] idx_error_count = 6'h15;
  localparam logic [5:0] idx_pcs_config = 6'h16;
  localparam logic [5:0] idx_irq_status = 6'h17;
  localparam logic [5:0] idx_irq_mask = 6'h18;
  localparam int addr_lsb = 2;
  localparam logic [7:0] tally_reset = 8'h00;
  localparam logic [7:0] tally_max = 8'hff;
  localparam logic [15:0] pcs_config_reset = 16'h0000;
  localparam int pos_auto_crossover = 15;
  localparam int pos_free_clk = 11;
  localparam int pos_quiet_tx = 10;
  localparam int pos_sd_override = 9;
  localparam int pos_rsvd_lo = 12;
  localparam int ev_counted = 0;
  localparam int ev_saturated = 1;
  localparam int num_events = 2;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  localparam int clk_period_ns = 40;
  localparam int crossover_dwell_ns = 40960;
  localparam int crossover_dwell_cycles = crossover_dwell_ns / clk_period_ns;

  typedef struct packed {
    logic auto_crossover;
    logic [2:0] rsvd;
    logic free_clk;
    logic quiet_tx;
    logic sd_override;
  } pcs_config_t;

  typedef struct packed {
    logic carrier;
    logic collision;
    logic symbol_error;
  } rx_status_t;

  typedef struct packed {
    logic mdi_crossed;
    logic rx_clk_free_run;
    logic quiet_transmit_enable;
    logic signal_detect_override;
  } line_ctrl_t;
endpackage : phy_mgmt_pkg

// *** verilog/rx_error_counter_pcs_config.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_error_counter_pcs_config (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire phy_mgmt_pkg::rx_status_t rx_status,
  input wire logic forced_mode,
  input wire logic link_good,
  output phy_mgmt_pkg::line_ctrl_t line_ctrl,
  output logic irq
);
  import phy_mgmt_pkg::*;

  rx_status_t sync1;
  rx_status_t sync2;
  logic car_d;
  logic err_seen;
  logic coll_seen;
  logic [7:0] receive_error_tally;
  pcs_config_t cfg;
  logic [num_events-1:0] irq_status;
  logic [num_events-1:0] irq_mask;
  logic [5:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic [15:0] dwell;
  logic rd_was_count;

  // Receive status decode
  wire car = sync2.carrier;
  wire car_start = car & ~car_d;
  wire car_end = car_d & ~car;
  wire next_err = car_start ? sync2.symbol_error
                : (err_seen | (car & sync2.symbol_error));
  wire next_coll = car_start ? sync2.collision
                 : (coll_seen | (car & sync2.collision));

  // Bus decode
  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire ar_hs = arvalid & arready;
  wire [5:0] ar_idx = araddr[7:addr_lsb];
  wire do_write = aw_held & w_held & ~bvalid;
  wire wr_count = do_write & (aw_idx == idx_error_count);
  wire wr_cfg = do_write & (aw_idx == idx_pcs_config);
  wire wr_stat = do_write & (aw_idx == idx_irq_status);
  wire wr_mask = do_write & (aw_idx == idx_irq_mask);
  wire wr_hit = wr_count | wr_cfg | wr_stat | wr_mask;
  wire rd_count = ar_hs & (ar_idx == idx_error_count);
  wire rd_cfg = ar_hs & (ar_idx == idx_pcs_config);
  wire rd_stat = ar_hs & (ar_idx == idx_irq_status);
  wire rd_mask = ar_hs & (ar_idx == idx_irq_mask);
  wire rd_hit = rd_count | rd_cfg | rd_stat | rd_mask;

  // Error tally update
  wire count_event = car_end & err_seen & ~coll_seen;
  wire tally_full = (receive_error_tally == tally_max);
  wire inc = count_event & (rd_count | ~tally_full);
  wire [7:0] tally_base = rd_count ? tally_reset : receive_error_tally;
  wire [7:0] next_tally = inc ? tally_base + 8'h01 : tally_base;

  // Config write and read images
  wire [15:0] cfg_word = {cfg.auto_crossover, cfg.rsvd, cfg.free_clk,
                          cfg.quiet_tx, cfg.sd_override, 9'h000};
  wire [15:0] cfg_merge = {w_strb[1] ? w_data[15:8] : cfg_word[15:8],
                           cfg_word[7:0]};
  wire [31:0] rd_word = rd_count ? {24'h000000, receive_error_tally}
                      : rd_cfg ? {16'h0000, cfg_word}
                      : rd_stat ? {30'h00000000, irq_status}
                      : rd_mask ? {30'h00000000, irq_mask}
                      : 32'h00000000;

  // Event flags
  wire [num_events-1:0] ev;
  assign ev[ev_counted] = inc;
  assign ev[ev_saturated] = inc & (next_tally == tally_max);
  wire [num_events-1:0] clr = (wr_stat & w_strb[0])
                            ? w_data[num_events-1:0] : '0;
  wire [num_events-1:0] next_status = (irq_status & ~clr) | ev;
  wire [num_events-1:0] next_mask = (wr_mask & w_strb[0])
                                  ? w_data[num_events-1:0] : irq_mask;
  wire next_irq = |(next_status & next_mask);

  // Crossover dwell timer
  wire hunting = cfg.auto_crossover & forced_mode & ~link_good;
  wire dwell_done = (dwell == 16'(crossover_dwell_cycles - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else if (ce) begin
      sync1 <= rx_status;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      car_d <= 1'b0;
      err_seen <= 1'b0;
      coll_seen <= 1'b0;
      receive_error_tally <= tally_reset;
    end else if (ce) begin
      car_d <= car;
      err_seen <= next_err;
      coll_seen <= next_coll;
      receive_error_tally <= next_tally;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= pcs_config_t'(pcs_config_reset[15:9]);
    end else if (ce && wr_cfg) begin
      cfg <= pcs_config_t'(cfg_merge[15:9]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      irq_status <= next_status;
      irq_mask <= next_mask;
      irq <= next_irq;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dwell <= 16'h0000;
      line_ctrl <= '0;
    end else if (ce) begin
      dwell <= (!hunting || dwell_done) ? 16'h0000 : dwell + 16'h0001;
      if (!cfg.auto_crossover) begin
        line_ctrl.mdi_crossed <= 1'b0;
      end else if (hunting && dwell_done) begin
        line_ctrl.mdi_crossed <= ~line_ctrl.mdi_crossed;
      end
      line_ctrl.rx_clk_free_run <= cfg.free_clk;
      line_ctrl.quiet_transmit_enable <= cfg.quiet_tx;
      line_ctrl.signal_detect_override <= cfg.sd_override;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 6'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= resp_okay;
    end else if (ce) begin
      if (aw_hs) begin
        aw_idx <= awaddr[7:addr_lsb];
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (w_hs) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? resp_okay : resp_slverr;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= resp_okay;
      rd_was_count <= 1'b0;
    end else if (ce) begin
      if (ar_hs) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_hit ? resp_okay : resp_slverr;
        rd_was_count <= rd_count;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  property p_upper_zero;
    @(posedge aclk) disable iff (!aresetn)
      (rvalid && rd_was_count) |-> (rdata[31:8] == 24'h000000);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("Upper count bits read nonzero");

  property p_count_up;
    @(posedge aclk) disable iff (!aresetn)
      (ce && count_event && !tally_full && !rd_count)
      |=> (receive_error_tally == $past(receive_error_tally) + 8'h01);
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("Tally did not advance on counted event");

  property p_once_per_carrier;
    @(posedge aclk) disable iff (!aresetn)
      (ce && car && !rd_count)
      |=> (receive_error_tally == $past(receive_error_tally));
  endproperty
  a_once_per_carrier: assert property (p_once_per_carrier)
    else $error("Tally moved during carrier");

  property p_no_collision_count;
    @(posedge aclk) disable iff (!aresetn)
      (ce && car_end && coll_seen && !rd_count)
      |=> $stable(receive_error_tally);
  endproperty
  a_no_collision_count: assert property (p_no_collision_count)
    else $error("Tally advanced on collision event");

  property p_saturate;
    @(posedge aclk) disable iff (!aresetn)
      (ce && tally_full && !rd_count) |=> (receive_error_tally == tally_max);
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("Tally wrapped past maximum");

  property p_clear_on_read;
    @(posedge aclk) disable iff (!aresetn)
      (ce && rd_count)
      |=> (rdata[7:0] == $past(receive_error_tally))
          && (receive_error_tally == {7'h00, $past(count_event)});
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("Count read did not return and clear");

  property p_crossover_off;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !cfg.auto_crossover) |=> !line_ctrl.mdi_crossed;
  endproperty
  a_crossover_off: assert property (p_crossover_off)
    else $error("Crossed pairs with crossover disabled");

  property p_free_clk;
    @(posedge aclk) disable iff (!aresetn)
      (ce && wr_cfg && w_strb[1]) ##1 ce
      |=> (line_ctrl.rx_clk_free_run == $past(w_data[pos_free_clk], 2));
  endproperty
  a_free_clk: assert property (p_free_clk)
    else $error("Receive clock mode not following write");

  property p_quiet_tx;
    @(posedge aclk) disable iff (!aresetn)
      ce |=> (line_ctrl.quiet_transmit_enable == $past(cfg.quiet_tx))
             && (cfg.quiet_tx == cfg_word[pos_quiet_tx]);
  endproperty
  a_quiet_tx: assert property (p_quiet_tx)
    else $error("Quiet transmit mode mismatch");

  property p_sd_override;
    @(posedge aclk) disable iff (!aresetn)
      (ce && rd_cfg)
      |=> (rdata[pos_sd_override] == line_ctrl.signal_detect_override)
          || !$past(ce);
  endproperty
  a_sd_override: assert property (p_sd_override)
    else $error("Signal detect override mismatch");

  property p_write_ignored;
    @(posedge aclk) disable iff (!aresetn)
      (ce && wr_count && !count_event && !rd_count)
      |=> $stable(receive_error_tally);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("Count register took a write");

  property p_event_sets;
    @(posedge aclk) disable iff (!aresetn)
      (ce && inc) |=> irq_status[ev_counted];
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("Counted event lost by status");

  property p_full_flag;
    @(posedge aclk) disable iff (!aresetn)
      (ce && inc && (next_tally == tally_max)) |=> irq_status[ev_saturated];
  endproperty
  a_full_flag: assert property (p_full_flag)
    else $error("Saturation event lost by status");

  property p_irq_level;
    @(posedge aclk) disable iff (!aresetn)
      irq == |(irq_status & irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt line disagrees with status");

  property p_ce_freeze;
    @(posedge aclk) disable iff (!aresetn)
      !ce |=> $stable(receive_error_tally) && $stable(cfg)
              && $stable(bvalid) && $stable(rvalid);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("State moved with clock enable low");
endmodule : rx_error_counter_pcs_config
`default_nettype wire

// *** dv/line_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  input wire logic aclk,
  output var phy_mgmt_pkg::rx_status_t rx_status
);
  import phy_mgmt_pkg::*;
  initial rx_status = '0;
  // One carrier event, errs bad symbols, optional collision
  task automatic frame(input int errs, input logic coll);
    rx_status <= '{carrier: 1'b1, collision: coll, symbol_error: 1'b0};
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      rx_status.symbol_error <= (i < errs);
    end
    @(posedge aclk);
    rx_status <= '0;
    repeat (6) @(posedge aclk);
  endtask : frame
endmodule : line_partner
`default_nettype wire

// *** dv/rx_error_counter_pcs_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_error_counter_pcs_config_tb;
  import phy_mgmt_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, forced_mode = 1'b0, link_good = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, mdi_prev;
  logic [1:0] bresp, rresp, resp;
  rx_status_t rx_status;
  line_ctrl_t line_ctrl;
  int failures = 0, num_checks = 0, wait_cnt;
  logic ce = 1'b1;
  localparam logic [7:0] count_addr = {idx_error_count, 2'b00};
  localparam logic [7:0] cfg_addr = {idx_pcs_config, 2'b00};
  localparam logic [7:0] stat_addr = {idx_irq_status, 2'b00};
  localparam logic [7:0] mask_addr = {idx_irq_mask, 2'b00};
  always #20 aclk = ~aclk;

  rx_error_counter_pcs_config dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rx_status(rx_status), .forced_mode(forced_mode),
    .link_good(link_good), .line_ctrl(line_ctrl), .irq(irq)
  );
  line_partner u_partner (.aclk(aclk), .rx_status(rx_status));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (30000) @(posedge aclk);
    failures++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(count_addr);
    chk(rd_val, {24'h0, tally_reset});
    chk({30'h0, resp}, {30'h0, resp_okay});
    rd(cfg_addr);
    chk(rd_val, {16'h0, pcs_config_reset});
    chk({28'h0, line_ctrl}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("reset test done");
    wr(count_addr, 32'hffffffff);
    chk({30'h0, resp}, {30'h0, resp_okay});
    rd(count_addr);
    chk(rd_val, 32'h0);
    u_partner.frame(5, 1'b0);
    rd(count_addr);
    chk(rd_val, 32'h1);
    rd(count_addr);
    chk(rd_val, 32'h0);
    u_partner.frame(3, 1'b1);
    rd(count_addr);
    chk(rd_val, 32'h0);
    u_partner.frame(0, 1'b0);
    rd(count_addr);
    chk(rd_val, 32'h0);
    $display("counting test done");
    rd(stat_addr);
    chk(rd_val, 32'h1);
    wr(mask_addr, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(stat_addr, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(mask_addr, 32'h0);
    u_partner.frame(2, 1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(stat_addr);
    chk(rd_val, 32'h1);
    rd(count_addr);
    chk(rd_val, 32'h1);
    $display("interrupt test done");
    repeat (int'(tally_max) + 2) u_partner.frame(1, 1'b0);
    rd(count_addr);
    chk(rd_val, {24'h0, tally_max});
    rd(stat_addr);
    chk(rd_val, 32'h3);
    wr(stat_addr, 32'h3);
    rd(stat_addr);
    chk(rd_val, 32'h0);
    $display("saturation test done");
    // Software turns auto-crossover on here, then forces the mode
    wr(cfg_addr, 32'hffffffff);
    rd(cfg_addr);
    chk(rd_val, 32'h0000fe00);
    repeat (2) @(posedge aclk);
    chk({28'h0, line_ctrl}, 32'h7);
    forced_mode <= 1'b1;
    mdi_prev = line_ctrl.mdi_crossed;
    wait_cnt = 0;
    while (line_ctrl.mdi_crossed === mdi_prev
           && wait_cnt < crossover_dwell_cycles + 100) begin
      @(posedge aclk);
      wait_cnt++;
    end
    chk({31'h0, line_ctrl.mdi_crossed}, {31'h0, ~mdi_prev});
    mdi_prev = line_ctrl.mdi_crossed;
    repeat (crossover_dwell_cycles - 4) @(posedge aclk);
    chk({31'h0, line_ctrl.mdi_crossed}, {31'h0, mdi_prev});
    repeat (8) @(posedge aclk);
    chk({31'h0, line_ctrl.mdi_crossed}, {31'h0, ~mdi_prev});
    link_good <= 1'b1;
    wr(cfg_addr, 32'h0);
    repeat (2) @(posedge aclk);
    chk({28'h0, line_ctrl}, 32'h0);
    forced_mode <= 1'b0;
    wr(cfg_addr, 32'h00000400);
    repeat (2) @(posedge aclk);
    chk({28'h0, line_ctrl}, 32'h2);
    wr(cfg_addr, 32'h00000a00);
    repeat (2) @(posedge aclk);
    chk({28'h0, line_ctrl}, 32'h5);
    $display("config test done");
    rd(8'h00);
    chk(rd_val, 32'h0);
    chk({30'h0, resp}, {30'h0, resp_slverr});
    wr(8'h04, 32'h1);
    chk({30'h0, resp}, {30'h0, resp_slverr});
    $display("unmapped test done");
    ce <= 1'b0;
    u_partner.frame(1, 1'b0);
    ce <= 1'b1;
    rd(count_addr);
    chk(rd_val, 32'h0);
    $display("clock enable test done");
    finish_test();
  end
endmodule : rx_error_counter_pcs_config_tb
`default_nettype wire
